// *** hw/ldap_core.sv ***
// reader access protection, configuration freeze and log read formats
`timescale 1ns/10ps
`default_nettype none
module ldap_core import ldap_pkg::*; (
    input wire logic sys_clk_i, // 40 MHz clock
    input wire logic rstn_i, // async reset, active low
    input wire logic clk_en_i, // freezes all state when low
    input wire logic battery_present_i, // low while battery is detached
    input wire logic wake_cmd_i, // reader command: sleep to standby
    input wire logic rtc_set_i, // real-time clock has been set
    input wire logic log_start_i, // start condition met
    input wire logic log_done_i, // logging session complete
    input wire logic log_busy_i, // logging event in progress
    input wire logic log_wr_i, // logger write strobe to flash
    input wire logic [ADDR_W-1:0] log_addr_i, // logger flash word address
    input wire logic [WORD_W-1:0] log_data_i, // logger flash data
    input wire logic [ALARM_W-1:0] log_alarm_set_i, // alarm set pulses from logger
    input wire logic rd_req_i, // reader read request
    input wire logic wr_req_i, // reader write request
    input wire logic [1:0] bank_i, // memory bank
    input wire logic [ADDR_W-1:0] word_addr_i, // word address in bank
    input wire logic [WORD_W-1:0] wr_data_i, // reader write data
    input wire logic [PW_W-1:0] password_i, // access password offered
    input wire logic [FMT_W-1:0] read_fmt_i, // bit0 encrypt, bit1 auth
    output logic [2:0] state_o, // logger state
    output logic cfg_frozen_o, // configuration has been copied
    output logic [CFG_WORDS*WORD_W-1:0] rtc_cfg_o, // running configuration
    output logic [ALARM_W-1:0] alarm_o, // sticky alarm flags
    output logic log_full_o, // last sample word written
    output logic rsp_valid_o, // reply strobe
    output logic rsp_err_o, // reply is an error
    output logic [ERR_W-1:0] rsp_code_o, // error code
    output logic [WORD_W-1:0] rsp_data_o, // read data
    output logic rsp_auth_valid_o, // authentication code attached
    output logic [WORD_W-1:0] rsp_mac_o // authentication code
);
    logic [WORD_W-1:0] rwm_mem [0:RWM_WORDS-1];
    logic [WORD_W-1:0] flash_mem [0:FLASH_WORDS-1];
    ldap_state_t state_reg;
    logic [CFG_WORDS*WORD_W-1:0] cfg_reg;
    logic cfg_loaded_reg;
    logic [ALARM_W-1:0] alarm_reg;
    logic log_full_reg;
    logic rsp_valid_reg;
    logic rsp_err_reg;
    logic [ERR_W-1:0] rsp_code_reg;
    logic [WORD_W-1:0] rsp_data_reg;
    logic rsp_auth_reg;
    logic [WORD_W-1:0] rsp_mac_reg;

    logic in_range;
    logic is_flash;
    logic is_alarm;
    ldap_midx_t rwm_idx;
    ldap_midx_t pw_hi_idx;
    ldap_midx_t pw_lo_idx;
    logic [PW_W-1:0] bank_pw;
    logic pw_ok;
    logic [KEY_W-1:0] key;
    logic [CFG_WORDS*WORD_W-1:0] cfg_src;
    logic [WORD_W-1:0] flash_rd;
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] ks_word;
    logic [WORD_W-1:0] mac_word;
    logic req_acc;
    logic wr_op;
    logic [ERR_W-1:0] err_code;
    logic wr_ok_rwm;
    logic log_wr_ok;
    logic rd_enc;
    logic rd_auth;
    logic cfg_copy;

    // bank and address decode
    always_comb begin
        in_range = 1'b0;
        is_flash = 1'b0;
        is_alarm = 1'b0;
        rwm_idx = RSV_BASE;
        if (bank_i == BANK_RSV) begin
            in_range = word_addr_i < RSV_WORDS;
            rwm_idx = RSV_BASE + ldap_midx_t'(word_addr_i);
        end else if (bank_i == BANK_EPC) begin
            in_range = word_addr_i < EPC_WORDS;
            rwm_idx = EPC_BASE + ldap_midx_t'(word_addr_i);
        end else if (bank_i == BANK_TID) begin
            in_range = word_addr_i < TID_WORDS;
            rwm_idx = TID_BASE + ldap_midx_t'(word_addr_i);
        end else if (word_addr_i < FLASH_WORDS) begin
            in_range = 1'b1;
            is_flash = 1'b1;
        end else if (word_addr_i < FLASH_WORDS + URWM_WORDS) begin
            in_range = 1'b1;
            rwm_idx = URWM_BASE + ldap_midx_t'(word_addr_i - FLASH_WORDS);
            is_alarm = word_addr_i == FLASH_WORDS + UALARM_OFS;
        end
    end

    // each bank has its own 32-bit password in the reserved bank; zero means open
    assign pw_hi_idx = RSV_BASE + PW_OFS + ldap_midx_t'({bank_i, 1'b0});
    assign pw_lo_idx = RSV_BASE + PW_OFS + ldap_midx_t'({bank_i, 1'b1});
    assign bank_pw = {rwm_mem[pw_hi_idx], rwm_mem[pw_lo_idx]};
    assign pw_ok = (bank_pw == '0) || (password_i == bank_pw);

    always_comb begin
        key = '0;
        cfg_src = '0;
        for (int i = 0; i < KEY_WORDS; i++) begin
            key[KEY_W-1-WORD_W*i -: WORD_W] = rwm_mem[RSV_BASE + KEY_OFS + ldap_midx_t'(i)];
        end
        for (int i = 0; i < CFG_WORDS; i++) begin
            cfg_src[CFG_WORDS*WORD_W-1-WORD_W*i -: WORD_W] =
                rwm_mem[URWM_BASE + ldap_midx_t'(UCFG_OFS) + ldap_midx_t'(i)];
        end
    end

    assign flash_rd = flash_mem[word_addr_i];
    assign rd_word = is_flash ? flash_rd : (is_alarm ? alarm_reg : rwm_mem[rwm_idx]);

    ldap_cipher u_ks (
        .key_i(key),
        .block_i({DOM_ENC, ldap_word_t'(word_addr_i)}),
        .word_o(ks_word)
    );

    ldap_cipher u_mac (
        .key_i(key),
        .block_i({flash_rd ^ DOM_MAC, ldap_word_t'(word_addr_i)}),
        .word_o(mac_word)
    );

    // a logging event blocks the air link, so requests then get no reply at all
    assign req_acc = clk_en_i && !log_busy_i && (rd_req_i || wr_req_i);
    assign wr_op = wr_req_i && !rd_req_i;

    always_comb begin
        err_code = ERR_NONE;
        if (!in_range) begin
            err_code = ERR_OVERRUN;
        end else if (wr_op && (is_flash || is_alarm)) begin
            err_code = ERR_LOCKED;
        end else if (!pw_ok && (wr_op || bank_i == BANK_RSV)) begin
            err_code = ERR_LOCKED;
        end
    end

    // config writes still land after the freeze; the copy below does not repeat until reset or battery removal clears cfg_loaded_reg
    assign wr_ok_rwm = req_acc && wr_op && (err_code == ERR_NONE);
    assign log_wr_ok = clk_en_i && log_wr_i && (state_reg == ST_LOGGING)
        && (log_addr_i < FLASH_WORDS);
    assign rd_enc = is_flash && read_fmt_i[FMT_ENC_BIT];
    assign rd_auth = is_flash && read_fmt_i[FMT_AUTH_BIT];
    assign cfg_copy = clk_en_i && battery_present_i && (state_reg == ST_STANDBY)
        && rtc_set_i && !cfg_loaded_reg;

    // storage arrays carry no reset; contents are not control state
    always_ff @(posedge sys_clk_i) begin
        if (wr_ok_rwm) begin
            rwm_mem[rwm_idx] <= wr_data_i;
        end
        if (log_wr_ok) begin
            flash_mem[log_addr_i] <= log_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_NOBATT;
        end else if (clk_en_i) begin
            if (!battery_present_i) begin
                state_reg <= ST_NOBATT;
            end else begin
                case (state_reg)
                    ST_NOBATT: state_reg <= ST_SLEEP;
                    ST_SLEEP: if (wake_cmd_i) begin
                        state_reg <= ST_STANDBY;
                    end
                    ST_STANDBY: if (rtc_set_i) begin
                        state_reg <= ST_READY;
                    end
                    ST_READY: if (log_start_i) begin
                        state_reg <= ST_LOGGING;
                    end
                    ST_LOGGING: if (log_done_i) begin
                        state_reg <= ST_DONE;
                    end
                    default: state_reg <= state_reg;
                endcase
            end
        end
    end

    // only reset or battery removal reopens the configuration
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_reg <= '0;
            cfg_loaded_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (!battery_present_i) begin
                cfg_loaded_reg <= 1'b0;
            end else if (cfg_copy) begin
                cfg_reg <= cfg_src;
                cfg_loaded_reg <= 1'b1;
            end
        end
    end

    // alarms are or-ed in only in the logging state and held until reset or battery removal clears them; nothing from the reader side touches them
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alarm_reg <= '0;
            log_full_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (!battery_present_i) begin
                alarm_reg <= '0;
                log_full_reg <= 1'b0;
            end else begin
                if (state_reg == ST_LOGGING) begin
                    alarm_reg <= alarm_reg | log_alarm_set_i;
                end
                if (log_wr_ok && log_addr_i == LOG_LAST) begin
                    log_full_reg <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rsp_valid_reg <= 1'b0;
            rsp_err_reg <= 1'b0;
            rsp_code_reg <= ERR_NONE;
            rsp_data_reg <= '0;
            rsp_auth_reg <= 1'b0;
            rsp_mac_reg <= '0;
        end else if (clk_en_i) begin
            rsp_valid_reg <= req_acc;
            if (req_acc) begin
                rsp_err_reg <= err_code != ERR_NONE;
                rsp_code_reg <= err_code;
                if (wr_op || err_code != ERR_NONE) begin
                    rsp_data_reg <= '0;
                    rsp_auth_reg <= 1'b0;
                    rsp_mac_reg <= '0;
                end else begin
                    rsp_data_reg <= rd_enc ? (rd_word ^ ks_word) : rd_word;
                    rsp_auth_reg <= rd_auth;
                    rsp_mac_reg <= rd_auth ? mac_word : '0;
                end
            end
        end
    end

    assign state_o = state_reg;
    assign cfg_frozen_o = cfg_loaded_reg;
    assign rtc_cfg_o = cfg_reg;
    assign alarm_o = alarm_reg;
    assign log_full_o = log_full_reg;
    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_err_o = rsp_err_reg;
    assign rsp_code_o = rsp_code_reg;
    assign rsp_data_o = rsp_data_reg;
    assign rsp_auth_valid_o = rsp_auth_reg;
    assign rsp_mac_o = rsp_mac_reg;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    AST_CFG_HOLD: assert property (
        cfg_loaded_reg && battery_present_i |=> $stable(rtc_cfg_o))
        else $error("configuration changed after freeze");
    AST_CFG_COPY: assert property (
        cfg_copy |=> state_reg == ST_READY && rtc_cfg_o == $past(cfg_src) && cfg_frozen_o)
        else $error("configuration copy on ready entry wrong");
    AST_ALARM_WR: assert property (
        req_acc && wr_op && is_alarm |=> rsp_valid_o && rsp_err_o && rsp_code_o == ERR_LOCKED)
        else $error("alarm location write not refused");
    AST_ALARM_STICKY: assert property (
        clk_en_i && battery_present_i |=> (alarm_reg & $past(alarm_reg)) == $past(alarm_reg))
        else $error("alarm flag cleared");
    AST_RWM_WR_LATE: assert property (
        req_acc && wr_op && (state_reg == ST_READY || state_reg == ST_LOGGING) && !is_flash
        && !is_alarm && in_range && pw_ok |=> rsp_valid_o && !rsp_err_o && $stable(rtc_cfg_o))
        else $error("permitted write in ready or logging state mishandled");
    AST_FLASH_WR: assert property (
        req_acc && wr_op && is_flash |=> rsp_err_o && rsp_code_o == ERR_LOCKED)
        else $error("reader flash write not refused");
    AST_ENC_READ: assert property (
        req_acc && !wr_op && is_flash && read_fmt_i[FMT_ENC_BIT]
        |=> rsp_data_o == ($past(flash_rd) ^ $past(ks_word)))
        else $error("encrypted read data wrong");
    AST_AUTH_READ: assert property (
        req_acc && !wr_op && rd_auth |=> rsp_auth_valid_o && rsp_mac_o == $past(mac_word))
        else $error("authentication code missing");
    AST_CLEAR_READ: assert property (
        req_acc && !wr_op && is_flash && read_fmt_i == '0
        |=> rsp_data_o == $past(flash_rd) && !rsp_auth_valid_o)
        else $error("clear read format wrong");
    AST_PW_DENY: assert property (
        req_acc && wr_op && in_range && !pw_ok
        |=> rsp_valid_o && rsp_err_o && rsp_code_o == ERR_LOCKED)
        else $error("write without password accepted");
    AST_EPC_RANGE: assert property (
        req_acc && bank_i == BANK_EPC && word_addr_i >= EPC_WORDS
        |=> rsp_code_o == ERR_OVERRUN)
        else $error("code bank overrun not reported");
    AST_FLASH_TOP: assert property (
        req_acc && !wr_op && bank_i == BANK_USER && word_addr_i < FLASH_WORDS |=> !rsp_err_o)
        else $error("flash read refused inside range");

    COV_FREEZE: cover property (cfg_copy ##1 state_reg == ST_READY);
    COV_ENC_AUTH: cover property (req_acc && !wr_op && rd_enc && rd_auth);
    COV_FLASH_WR: cover property (req_acc && wr_op && is_flash);
    COV_LOG_FULL: cover property ($rose(log_full_o));
endmodule
`default_nettype wire

// *** include/ldap_pkg.sv ***
// constants, types and states of the logger data access protection block
package ldap_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 13;
    localparam int MIDX_W = 8;
    localparam int PW_W = 32;
    localparam int KEY_W = 128;
    localparam int BLK_W = 32;
    localparam int CFG_WORDS = 8;
    localparam int KEY_WORDS = 8;
    localparam int ALARM_W = 16;
    localparam int CIPH_ROUNDS = 8;
    localparam int ERR_W = 8;
    localparam int FMT_W = 2;
    localparam int FMT_ENC_BIT = 0;
    localparam int FMT_AUTH_BIT = 1;

    typedef logic [WORD_W-1:0] ldap_word_t;
    typedef logic [ADDR_W-1:0] ldap_addr_t;
    typedef logic [MIDX_W-1:0] ldap_midx_t;

    // bank sizes and flash layout, word addresses
    localparam ldap_addr_t RSV_WORDS = 13'h0014;
    localparam ldap_addr_t EPC_WORDS = 13'h0010;
    localparam ldap_addr_t TID_WORDS = 13'h0040;
    localparam ldap_addr_t URWM_WORDS = 13'h0090;
    localparam ldap_addr_t FLASH_WORDS = 13'h1090;
    localparam ldap_addr_t LOG_WORDS = 13'h1000;
    localparam ldap_addr_t LOG_LAST = LOG_WORDS - 13'h0001;
    localparam ldap_addr_t UCFG_OFS = 13'h0000;
    localparam ldap_addr_t UALARM_OFS = 13'h0008;

    // placement of the banks inside the one rewritable array
    localparam ldap_midx_t RSV_BASE = 8'h00;
    localparam ldap_midx_t EPC_BASE = 8'h14;
    localparam ldap_midx_t TID_BASE = 8'h24;
    localparam ldap_midx_t URWM_BASE = 8'h64;
    localparam ldap_midx_t RWM_WORDS = 8'hF4;
    localparam ldap_midx_t PW_OFS = 8'h00;
    localparam ldap_midx_t KEY_OFS = 8'h08;

    localparam logic [1:0] BANK_RSV = 2'h0;
    localparam logic [1:0] BANK_EPC = 2'h1;
    localparam logic [1:0] BANK_TID = 2'h2;
    localparam logic [1:0] BANK_USER = 2'h3;

    localparam logic [ERR_W-1:0] ERR_NONE = 8'h00;
    localparam logic [ERR_W-1:0] ERR_OVERRUN = 8'h03;
    localparam logic [ERR_W-1:0] ERR_LOCKED = 8'h04;

    localparam ldap_word_t DOM_ENC = 16'hA5C3;
    localparam ldap_word_t DOM_MAC = 16'h3C5A;
    localparam logic [BLK_W-1:0] ROUND_CONST = 32'h9E37_79B9;

    typedef enum logic [2:0] {
        ST_NOBATT = 3'b000,
        ST_SLEEP = 3'b001,
        ST_STANDBY = 3'b010,
        ST_READY = 3'b011,
        ST_LOGGING = 3'b100,
        ST_DONE = 3'b101
    } ldap_state_t;
endpackage

// *** hw/ldap_cipher.sv ***
// keyed word transform used for log encryption and authentication codes
`timescale 1ns/10ps
`default_nettype none
module ldap_cipher import ldap_pkg::*; (
    input wire logic [KEY_W-1:0] key_i, // 128-bit key
    input wire logic [BLK_W-1:0] block_i, // domain word and address or data
    output logic [WORD_W-1:0] word_o // transformed word
);
    always_comb begin
        logic [BLK_W-1:0] s;
        s = block_i;
        for (int r = 0; r < CIPH_ROUNDS; r++) begin
            s = s ^ key_i[BLK_W*(r % (KEY_W/BLK_W)) +: BLK_W];
            s = {s[BLK_W-9:0], s[BLK_W-1:BLK_W-8]} ^ (s & {s[BLK_W-2:0], s[BLK_W-1]});
            s = s + (ROUND_CONST ^ BLK_W'(r));
        end
        word_o = s[BLK_W-1:WORD_W] ^ s[WORD_W-1:0];
    end
endmodule
`default_nettype wire

// *** verif/ldap_reader.sv ***
// reader-side model that places requests on the access port
`timescale 1ns/10ps
`default_nettype none
module ldap_reader import ldap_pkg::*; (
    input wire logic clk_i, // system clock
    output logic rd_req_o, // read request
    output logic wr_req_o, // write request
    output logic [1:0] bank_o, // memory bank
    output logic [ADDR_W-1:0] addr_o, // word address
    output logic [WORD_W-1:0] data_o, // write data
    output logic [PW_W-1:0] pw_o, // access password
    output logic [FMT_W-1:0] fmt_o // read format
);
    initial begin
        rd_req_o = 1'b0;
        wr_req_o = 1'b0;
        bank_o = 2'h0;
        addr_o = 13'h0000;
        data_o = 16'h0000;
        pw_o = 32'h0000_0000;
        fmt_o = 2'h0;
    end

    // one request per call; released address, data and password lines show inverted values so stale data never matches
    task automatic access(input logic wr, input logic [1:0] bank, input logic [ADDR_W-1:0] addr,
        input logic [WORD_W-1:0] data, input logic [PW_W-1:0] pw, input logic [FMT_W-1:0] fmt);
        @(posedge clk_i);
        rd_req_o <= !wr;
        wr_req_o <= wr;
        bank_o <= bank;
        addr_o <= addr;
        data_o <= data;
        pw_o <= pw;
        fmt_o <= fmt;
        @(posedge clk_i);
        rd_req_o <= 1'b0;
        wr_req_o <= 1'b0;
        addr_o <= ~addr;
        data_o <= ~data;
        pw_o <= ~pw;
    endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the access protection core
`timescale 1ns/10ps
`default_nettype none
module tb_top import ldap_pkg::*; ();
    typedef struct packed {
        logic err;
        logic [ERR_W-1:0] code;
        logic [WORD_W-1:0] data;
        logic chk;
        logic auth;
    } ldap_note_t;
    localparam logic [PW_W-1:0] UPW = 32'h1234_5678;
    logic sys_clk_i, rstn_i, clk_en_i, battery_present_i, wake_cmd_i, rtc_set_i;
    logic log_start_i, log_done_i, log_busy_i, log_wr_i, rd_req_i, wr_req_i;
    logic [ADDR_W-1:0] log_addr_i, word_addr_i;
    logic [WORD_W-1:0] log_data_i, wr_data_i, rsp_data_o, rsp_mac_o, last_data, last_mac;
    logic [WORD_W-1:0] fd, e1, m2;
    logic [KEY_W-1:0] key_exp;
    logic [ALARM_W-1:0] log_alarm_set_i, alarm_o;
    logic [1:0] bank_i;
    logic [PW_W-1:0] password_i;
    logic [FMT_W-1:0] read_fmt_i;
    logic [2:0] state_o;
    logic cfg_frozen_o, log_full_o, rsp_valid_o, rsp_err_o, rsp_auth_valid_o;
    logic [CFG_WORDS*WORD_W-1:0] rtc_cfg_o, cfg_exp;
    logic [ERR_W-1:0] rsp_code_o;
    logic [31:0] seed = 32'hd883_b64c;
    ldap_note_t notes[$];
    ldap_note_t nt;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    ldap_core dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
        .battery_present_i(battery_present_i), .wake_cmd_i(wake_cmd_i), .rtc_set_i(rtc_set_i),
        .log_start_i(log_start_i), .log_done_i(log_done_i), .log_busy_i(log_busy_i),
        .log_wr_i(log_wr_i), .log_addr_i(log_addr_i), .log_data_i(log_data_i),
        .log_alarm_set_i(log_alarm_set_i), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i),
        .bank_i(bank_i), .word_addr_i(word_addr_i), .wr_data_i(wr_data_i),
        .password_i(password_i), .read_fmt_i(read_fmt_i), .state_o(state_o),
        .cfg_frozen_o(cfg_frozen_o), .rtc_cfg_o(rtc_cfg_o), .alarm_o(alarm_o),
        .log_full_o(log_full_o), .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
        .rsp_code_o(rsp_code_o), .rsp_data_o(rsp_data_o),
        .rsp_auth_valid_o(rsp_auth_valid_o), .rsp_mac_o(rsp_mac_o));
    ldap_reader rdr (.clk_i(sys_clk_i), .rd_req_o(rd_req_i), .wr_req_o(wr_req_i),
        .bank_o(bank_i), .addr_o(word_addr_i), .data_o(wr_data_i), .pw_o(password_i),
        .fmt_o(read_fmt_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // mirror of the keyed word transform, to predict encrypted words and codes
    function automatic logic [WORD_W-1:0] ciph(input logic [KEY_W-1:0] k,
        input logic [BLK_W-1:0] b);
        for (int r = 0; r < CIPH_ROUNDS; r++) begin
            b ^= k[BLK_W*(r % (KEY_W/BLK_W)) +: BLK_W];
            b = {b[BLK_W-9:0], b[BLK_W-1:BLK_W-8]} ^ (b & {b[BLK_W-2:0], b[BLK_W-1]});
            b = b + (ROUND_CONST ^ BLK_W'(r));
        end
        return b[BLK_W-1:WORD_W] ^ b[WORD_W-1:0];
    endfunction

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wrt(input logic [1:0] b, input ldap_addr_t a, input ldap_word_t d,
        input logic [PW_W-1:0] pw, input logic [ERR_W-1:0] c);
        notes.push_back('{c != ERR_NONE, c, 16'h0000, 1'b1, 1'b0});
        rdr.access(1'b1, b, a, d, pw, 2'h0);
    endtask

    task automatic rd(input logic [1:0] b, input ldap_addr_t a, input logic [FMT_W-1:0] f,
        input logic [ERR_W-1:0] c, input ldap_word_t ed, input logic chk, input logic au);
        notes.push_back('{c != ERR_NONE, c, ed, chk, au});
        rdr.access(1'b0, b, a, 16'h0000, UPW, f);
    endtask

    task automatic strobe(input logic [3:0] sel);
        @(posedge sys_clk_i);
        {wake_cmd_i, rtc_set_i, log_start_i, log_done_i} <= sel;
        @(posedge sys_clk_i);
        {wake_cmd_i, rtc_set_i, log_start_i, log_done_i} <= 4'h0;
        tick(1);
    endtask

    task automatic lwr(input ldap_addr_t a, input ldap_word_t d);
        @(posedge sys_clk_i);
        log_wr_i <= 1'b1;
        log_addr_i <= a;
        log_data_i <= d;
        @(posedge sys_clk_i);
        log_wr_i <= 1'b0;
    endtask

    // a reply with no pending note is a refused request that answered anyway
    always @(posedge sys_clk_i) begin
        if (rsp_valid_o === 1'b1) begin
            if (notes.size() == 0) begin
                check(1'b1, 1'b0);
            end else begin
                nt = notes.pop_front();
                check(rsp_err_o, nt.err);
                check(rsp_code_o, nt.code);
                if (nt.chk) check(rsp_data_o, nt.data);
                check(rsp_auth_valid_o, nt.auth);
                last_data = rsp_data_o;
                last_mac = rsp_mac_o;
            end
        end
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        {rstn_i, wake_cmd_i, rtc_set_i, log_start_i, log_done_i, log_busy_i, log_wr_i} = 7'h00;
        {clk_en_i, battery_present_i} = 2'h3;
        log_addr_i = 13'h0000;
        log_data_i = 16'h0000;
        log_alarm_set_i = 16'h0000;
        repeat (5) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        tick(2);
        check(state_o, ST_SLEEP);
        strobe(4'h8);
        check(state_o, ST_STANDBY);
        for (int b = 0; b < 4; b++) begin
            wrt(BANK_RSV, ldap_addr_t'(2 * b + 1), 16'h0000, 32'h0000_0000, ERR_NONE);
            wrt(BANK_RSV, ldap_addr_t'(2 * b), 16'h0000, 32'h0000_0000, ERR_NONE);
        end
        for (int k = 8; k < 16; k++) begin
            seed = xs(seed);
            key_exp = {key_exp[111:0], seed[15:0]};
            wrt(BANK_RSV, ldap_addr_t'(k), seed[15:0], 32'h0000_0000, ERR_NONE);
        end
        wrt(BANK_RSV, 13'h0007, UPW[15:0], 32'h0000_0000, ERR_NONE);
        wrt(BANK_RSV, 13'h0006, UPW[31:16], 32'h0000_0000, ERR_NONE);
        for (int i = 0; i < CFG_WORDS; i++) begin
            seed = xs(seed);
            cfg_exp = {cfg_exp[111:0], seed[15:0]};
            wrt(BANK_USER, FLASH_WORDS + UCFG_OFS + ldap_addr_t'(i), seed[15:0], UPW, ERR_NONE);
        end
        // refusals: wrong password, alarm word, flash, out of range per bank
        wrt(BANK_USER, FLASH_WORDS, 16'hDEAD, 32'h0000_0001, ERR_LOCKED);
        wrt(BANK_USER, FLASH_WORDS + UALARM_OFS, 16'hFFFF, UPW, ERR_LOCKED);
        wrt(BANK_USER, 13'h0064, 16'h5A5A, UPW, ERR_LOCKED);
        wrt(BANK_USER, FLASH_WORDS + URWM_WORDS, 16'h0001, UPW, ERR_OVERRUN);
        rd(BANK_USER, FLASH_WORDS, 2'h0, ERR_NONE, cfg_exp[127:112], 1'b1, 1'b0);
        rd(BANK_EPC, EPC_WORDS - 13'h0001, 2'h0, ERR_NONE, 16'h0000, 1'b0, 1'b0);
        rd(BANK_EPC, EPC_WORDS, 2'h0, ERR_OVERRUN, 16'h0000, 1'b1, 1'b0);
        rd(BANK_TID, TID_WORDS, 2'h0, ERR_OVERRUN, 16'h0000, 1'b1, 1'b0);
        rd(BANK_RSV, RSV_WORDS, 2'h0, ERR_OVERRUN, 16'h0000, 1'b1, 1'b0);
        strobe(4'h4);
        check(state_o, ST_READY);
        check(cfg_frozen_o, 1'b1);
        check(rtc_cfg_o, cfg_exp);
        wrt(BANK_USER, FLASH_WORDS, 16'h0F0F, UPW, ERR_NONE);
        rd(BANK_USER, FLASH_WORDS, 2'h0, ERR_NONE, 16'h0F0F, 1'b1, 1'b0);
        strobe(4'h4);
        check(rtc_cfg_o, cfg_exp);
        strobe(4'h2);
        check(state_o, ST_LOGGING);
        seed = xs(seed);
        fd = seed[15:0];
        lwr(13'h0000, fd);
        lwr(LOG_LAST - 13'h0001, ~fd);
        tick(1);
        check(log_full_o, 1'b0);
        lwr(LOG_LAST, fd);
        tick(1);
        check(log_full_o, 1'b1);
        @(posedge sys_clk_i);
        log_alarm_set_i <= 16'h0005;
        @(posedge sys_clk_i);
        log_alarm_set_i <= 16'h0000;
        rd(BANK_USER, FLASH_WORDS + UALARM_OFS, 2'h0, ERR_NONE, 16'h0005, 1'b1, 1'b0);
        wrt(BANK_USER, FLASH_WORDS + UALARM_OFS, 16'h0000, UPW, ERR_LOCKED);
        wrt(BANK_USER, 13'h0000, ~fd, UPW, ERR_LOCKED);
        tick(3);
        check(alarm_o, 16'h0005);
        check(rtc_cfg_o, cfg_exp);
        e1 = fd ^ ciph(key_exp, {DOM_ENC, 16'h0000});
        m2 = ciph(key_exp, {fd ^ DOM_MAC, 16'h0000});
        rd(BANK_USER, 13'h0000, 2'h0, ERR_NONE, fd, 1'b1, 1'b0);
        rd(BANK_USER, 13'h0000, 2'h1, ERR_NONE, e1, 1'b1, 1'b0);
        rd(BANK_USER, 13'h0000, 2'h2, ERR_NONE, fd, 1'b1, 1'b1);
        tick(3);
        check(last_mac, m2);
        rd(BANK_USER, 13'h0000, 2'h3, ERR_NONE, e1, 1'b1, 1'b1);
        tick(3);
        check(last_data, e1);
        check(last_mac, m2);
        // no note pushed: any reply to these is caught by the watcher
        @(posedge sys_clk_i);
        log_busy_i <= 1'b1;
        rdr.access(1'b0, BANK_USER, 13'h0000, 16'h0000, UPW, 2'h0);
        log_busy_i <= 1'b0;
        clk_en_i <= 1'b0;
        rdr.access(1'b1, BANK_USER, FLASH_WORDS, 16'h0000, UPW, 2'h0);
        clk_en_i <= 1'b1;
        strobe(4'h1);
        check(state_o, ST_DONE);
        @(posedge sys_clk_i);
        battery_present_i <= 1'b0;
        tick(2);
        check(state_o, ST_NOBATT);
        check(cfg_frozen_o, 1'b0);
        check(alarm_o, 16'h0000);
        @(posedge sys_clk_i);
        battery_present_i <= 1'b1;
        tick(2);
        check(state_o, ST_SLEEP);
        check(notes.size(), 0);
        summarize();
    end
endmodule
`default_nettype wire
